// ==== logic/can_irq_pkg.sv ====
// shared constants, field layouts and carrier types of the can interrupt enable logic
`default_nettype none
package can_irq_pkg;

  // --------------------------------------------------------------
  // bus geometry
  // --------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h04;  // sticky summary, wake-up, sleep flags
  localparam logic [7:0] OFF_FIFO0 = 8'h0c;   // receive fifo 0 state
  localparam logic [7:0] OFF_FIFO1 = 8'h10;   // receive fifo 1 state
  localparam logic [7:0] OFF_ENABLE = 8'h14;  // interrupt enable
  localparam logic [7:0] OFF_ERROR = 8'h18;   // error state, read only

  // --------------------------------------------------------------
  // interrupt enable register layout
  // --------------------------------------------------------------
  localparam int EN_TX = 0;
  localparam int EN_F0_PEND = 1;
  localparam int EN_F0_FULL = 2;
  localparam int EN_F0_OVR = 3;
  localparam int EN_F1_PEND = 4;
  localparam int EN_F1_FULL = 5;
  localparam int EN_F1_OVR = 6;
  localparam int EN_WARN = 8;
  localparam int EN_PASSIVE = 9;
  localparam int EN_BUS_OFF = 10;
  localparam int EN_LAST_ERR = 11;
  localparam int EN_ERR_MASTER = 15;
  localparam int EN_WAKEUP = 16;
  localparam int EN_SLEEP = 17;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_MASK = 32'h0003_8f7f;  // writable bits only

  // --------------------------------------------------------------
  // status, fifo and error register layouts
  // --------------------------------------------------------------
  localparam int ST_ERR_SUMMARY = 0;
  localparam int ST_WAKEUP = 1;
  localparam int ST_SLEEP = 2;
  localparam int FIFO_CNT_LSB = 0;
  localparam int FIFO_FULL = 3;
  localparam int FIFO_OVR = 4;
  localparam int FIFO_REL = 5;
  localparam int ERR_WARN = 0;
  localparam int ERR_PASSIVE = 1;
  localparam int ERR_BUS_OFF = 2;
  localparam int ERR_LEC_LSB = 4;
  localparam int ERR_TXC_LSB = 16;
  localparam int ERR_RXC_LSB = 24;

  // --------------------------------------------------------------
  // limits and answers
  // --------------------------------------------------------------
  localparam logic [1:0] FIFO_DEPTH = 2'h3;        // messages held when full
  localparam logic [8:0] WARN_LIMIT = 9'h060;      // 96, warning at or above
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;   // 127, passive at or above
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;   // 255, bus-off strictly above
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

  // flags and counters arriving from the protocol engine
  typedef struct packed {
    logic [2:0] mailbox_request_done;  // level per transmit mailbox
    logic fifo0_msg_in;                // pulse, message stored in fifo 0
    logic fifo1_msg_in;                // pulse, message stored in fifo 1
    logic [8:0] tx_err_count;
    logic [7:0] rx_err_count;
    logic [2:0] last_error_code;
    logic last_error_set;              // pulse, new code recorded
    logic wakeup_event;                // pulse
    logic sleep_event;                 // pulse
  } engine_in_t;

  // state of one receive fifo
  typedef struct packed {
    logic [1:0] count;
    logic full;
    logic overrun;
  } fifo_state_t;

  // interrupt request levels
  typedef struct packed {
    logic tx;
    logic fifo0_pending;
    logic fifo0_full;
    logic fifo0_overrun;
    logic fifo1_pending;
    logic fifo1_full;
    logic fifo1_overrun;
    logic error;
    logic wakeup;
    logic sleep;
  } irq_req_t;

endpackage
`default_nettype wire

// ==== logic/sticky_flag.sv ====
// sticky flag set by hardware and cleared by software, set winning
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // hardware event and software clear
  input wire logic set,
  input wire logic clear,
  // held flag
  output logic flag
);

  // a set in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag <= 1'h0;
    end else if (set) begin
      flag <= 1'h1;
    end else if (clear) begin
      flag <= 1'h0;
    end
  end

endmodule // sticky_flag
`default_nettype wire

// ==== logic/fifo_msg_status.sv ====
// message count, full and overrun flags of one receive fifo
`timescale 1ns/10ps
`default_nettype none
module fifo_msg_status (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // engine and software events
  input wire logic msg_in,
  input wire logic release_req,
  input wire logic clear_full,
  input wire logic clear_overrun,
  // fifo view
  output can_irq_pkg::fifo_state_t state
);

  logic [1:0] count;       // messages held
  logic [1:0] next_count;  // count after this cycle
  logic full_flag;
  logic overrun_flag;

  // a message is stored only while room remains
  wire accept = msg_in && (count != can_irq_pkg::FIFO_DEPTH);
  wire drop = release_req && (count != 2'h0);
  wire reach_full = accept && !drop && (count == can_irq_pkg::FIFO_DEPTH - 2'h1);
  // a message arriving when full is lost and flagged
  wire lost = msg_in && (count == can_irq_pkg::FIFO_DEPTH);

  // up by one per message, down by one per release
  always_comb begin
    next_count = count;
    if (accept && !drop) begin
      next_count = count + 2'h1;
    end else if (drop && !accept) begin
      next_count = count - 2'h1;
    end
  end

  // count register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 2'h0;
    end else begin
      count <= next_count;
    end
  end

  // full flag, write one clears
  sticky_flag full_i (
    .clk(clk),
    .resetn(resetn),
    .set(reach_full),
    .clear(clear_full),
    .flag(full_flag)
  );

  // overrun flag, write one clears
  sticky_flag overrun_i (
    .clk(clk),
    .resetn(resetn),
    .set(lost),
    .clear(clear_overrun),
    .flag(overrun_flag)
  );

  assign state.count = count;
  assign state.full = full_flag;
  assign state.overrun = overrun_flag;

endmodule // fifo_msg_status
`default_nettype wire

// ==== logic/can_irq_enable_logic.sv ====
// interrupt enable and request logic of a can controller with an avalon-mm register slave
//
// Functional notes
// - transmit request on mailbox done when enabled
// - fifo 0 pending request when count nonzero
// - fifo 0 full request when flag enabled
// - fifo 0 overrun request when flag enabled
// - fifo 1 pending request when count nonzero
// - fifo 1 full request when flag enabled
// - fifo 1 overrun request when flag enabled
// - warning rise sets summary flag if enabled
// - passive rise sets summary flag if enabled
// - bus-off rise sets summary flag if enabled
// - new last error code sets summary flag if enabled
// - error request needs summary flag and master
// - wake-up request when pending and enabled
// - sleep request when entered and enabled
// - enable register at 0x14 resets zero
// - fifo count up per message, down per release
// - full at three, overrun beyond, write-one clears
// - warning when either error counter reaches 96
`timescale 1ns/10ps
`default_nettype none
module can_irq_enable_logic (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  // protocol engine flags and counters
  input wire can_irq_pkg::engine_in_t engine,
  // output mailbox release towards the engine
  output logic fifo0_release,
  output logic fifo1_release,
  // interrupt request levels
  output can_irq_pkg::irq_req_t irq
);

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  can_irq_pkg::bus_state_t bus_state;       // slave handshake state
  can_irq_pkg::bus_state_t next_bus_state;
  logic [31:0] enable;                      // interrupt enable register
  logic warn_prev;                          // error levels one cycle ago
  logic passive_prev;
  logic bus_off_prev;
  logic err_summary;                        // sticky summary error flag
  logic wakeup_flag;                        // sticky wake-up pending
  logic sleep_flag;                         // sticky sleep entered
  can_irq_pkg::fifo_state_t fifo0;          // fifo 0 count and flags
  can_irq_pkg::fifo_state_t fifo1;          // fifo 1 count and flags
  can_irq_pkg::irq_req_t next_irq;          // request levels before the flop

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  // full byte address compare, so misaligned addresses are unmapped
  wire hit_status = (address == can_irq_pkg::OFF_STATUS);
  wire hit_fifo0 = (address == can_irq_pkg::OFF_FIFO0);
  wire hit_fifo1 = (address == can_irq_pkg::OFF_FIFO1);
  wire hit_enable = (address == can_irq_pkg::OFF_ENABLE);
  wire hit_error = (address == can_irq_pkg::OFF_ERROR);
  wire hit_any = hit_status || hit_fifo0 || hit_fifo1 || hit_enable || hit_error;

  // byte lanes widened to a bit mask
  wire [31:0] lane_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [31:0] wdata = writedata & lane_mask;

  // --------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------
  // one wait state: the request is taken in idle, answered next cycle
  wire bus_req = read || write;
  wire in_idle = (bus_state == can_irq_pkg::BUS_IDLE);
  wire take_req = bus_req && in_idle;
  // a write acts only at the edge where waitrequest is low
  wire wr_commit = write && (bus_state == can_irq_pkg::BUS_ANSWER);

  assign waitrequest = bus_req && in_idle;

  // state advance
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      // wait for a request
      can_irq_pkg::BUS_IDLE: begin
        if (take_req) begin
          next_bus_state = can_irq_pkg::BUS_ANSWER;
        end
      end
      // answer cycle, always back to idle
      can_irq_pkg::BUS_ANSWER: begin
        next_bus_state = can_irq_pkg::BUS_IDLE;
      end
      // stray code recovers to idle
      default: begin
        next_bus_state = can_irq_pkg::BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_state <= can_irq_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // --------------------------------------------------------------
  // software strobes
  // --------------------------------------------------------------
  wire wr_status = wr_commit && hit_status;
  wire wr_fifo0 = wr_commit && hit_fifo0;
  wire wr_fifo1 = wr_commit && hit_fifo1;
  wire wr_enable = wr_commit && hit_enable;

  // write-one clears of the sticky status flags and write-one fifo releases
  wire clr_summary = wr_status && wdata[can_irq_pkg::ST_ERR_SUMMARY];
  wire clr_wakeup = wr_status && wdata[can_irq_pkg::ST_WAKEUP];
  wire clr_sleep = wr_status && wdata[can_irq_pkg::ST_SLEEP];
  wire clr_f0_full = wr_fifo0 && wdata[can_irq_pkg::FIFO_FULL];
  wire clr_f0_ovr = wr_fifo0 && wdata[can_irq_pkg::FIFO_OVR];
  wire clr_f1_full = wr_fifo1 && wdata[can_irq_pkg::FIFO_FULL];
  wire clr_f1_ovr = wr_fifo1 && wdata[can_irq_pkg::FIFO_OVR];
  wire rel_f0 = wr_fifo0 && wdata[can_irq_pkg::FIFO_REL];
  wire rel_f1 = wr_fifo1 && wdata[can_irq_pkg::FIFO_REL];

  // --------------------------------------------------------------
  // interrupt enable register
  // --------------------------------------------------------------
  // reserved bits never take a write
  wire [31:0] en_wmask = lane_mask & can_irq_pkg::ENABLE_MASK;
  wire [31:0] next_enable = (enable & ~en_wmask) | (wdata & en_wmask);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      enable <= can_irq_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable <= next_enable;
    end
  end

  // --------------------------------------------------------------
  // receive fifo state
  // --------------------------------------------------------------
  // count for fifo 0
  fifo_msg_status fifo0_i (
    .clk(clk),
    .resetn(resetn),
    .msg_in(engine.fifo0_msg_in),
    .release_req(rel_f0),
    .clear_full(clr_f0_full),
    .clear_overrun(clr_f0_ovr),
    .state(fifo0)
  );

  fifo_msg_status fifo1_i (
    .clk(clk),
    .resetn(resetn),
    .msg_in(engine.fifo1_msg_in),
    .release_req(rel_f1),
    .clear_full(clr_f1_full),
    .clear_overrun(clr_f1_ovr),
    .state(fifo1)
  );

  // release pulses tell the engine to step its output mailbox
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fifo0_release <= 1'h0;
      fifo1_release <= 1'h0;
    end else begin
      fifo0_release <= rel_f0;
      fifo1_release <= rel_f1;
    end
  end

  // --------------------------------------------------------------
  // error levels from the counters
  // --------------------------------------------------------------
  wire [8:0] rx_count_wide = {1'h0, engine.rx_err_count};
  // warning at 96 on either counter
  wire warn_now = (engine.tx_err_count >= can_irq_pkg::WARN_LIMIT) ||
                  (rx_count_wide >= can_irq_pkg::WARN_LIMIT);
  wire passive_now = (engine.tx_err_count >= can_irq_pkg::PASSIVE_LIMIT) ||
                     (rx_count_wide >= can_irq_pkg::PASSIVE_LIMIT);
  wire bus_off_now = (engine.tx_err_count > can_irq_pkg::BUS_OFF_LIMIT);

  // previous levels for rise detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      warn_prev <= 1'h0;
      passive_prev <= 1'h0;
      bus_off_prev <= 1'h0;
    end else begin
      warn_prev <= warn_now;
      passive_prev <= passive_now;
      bus_off_prev <= bus_off_now;
    end
  end

  // a level already high when enabled does not count; only its rise does
  // warning rise, gated
  wire set_by_warn = warn_now && !warn_prev && enable[can_irq_pkg::EN_WARN];
  wire set_by_passive = passive_now && !passive_prev && enable[can_irq_pkg::EN_PASSIVE];
  wire set_by_bus_off = bus_off_now && !bus_off_prev && enable[can_irq_pkg::EN_BUS_OFF];
  wire set_by_lec = engine.last_error_set && enable[can_irq_pkg::EN_LAST_ERR];
  wire set_summary = set_by_warn || set_by_passive || set_by_bus_off || set_by_lec;

  // --------------------------------------------------------------
  // sticky status flags
  // --------------------------------------------------------------
  // summary error flag
  sticky_flag summary_i (
    .clk(clk),
    .resetn(resetn),
    .set(set_summary),
    .clear(clr_summary),
    .flag(err_summary)
  );

  // wake-up pending flag
  sticky_flag wakeup_i (
    .clk(clk),
    .resetn(resetn),
    .set(engine.wakeup_event),
    .clear(clr_wakeup),
    .flag(wakeup_flag)
  );

  // sleep entered flag
  sticky_flag sleep_i (
    .clk(clk),
    .resetn(resetn),
    .set(engine.sleep_event),
    .clear(clr_sleep),
    .flag(sleep_flag)
  );

  // --------------------------------------------------------------
  // request levels
  // --------------------------------------------------------------
  // any finished mailbox
  assign next_irq.tx = (|engine.mailbox_request_done) && enable[can_irq_pkg::EN_TX];
  assign next_irq.fifo0_pending = (fifo0.count != 2'h0) && enable[can_irq_pkg::EN_F0_PEND];
  assign next_irq.fifo0_full = fifo0.full && enable[can_irq_pkg::EN_F0_FULL];
  assign next_irq.fifo0_overrun = fifo0.overrun && enable[can_irq_pkg::EN_F0_OVR];
  assign next_irq.fifo1_pending = (fifo1.count != 2'h0) && enable[can_irq_pkg::EN_F1_PEND];
  assign next_irq.fifo1_full = fifo1.full && enable[can_irq_pkg::EN_F1_FULL];
  assign next_irq.fifo1_overrun = fifo1.overrun && enable[can_irq_pkg::EN_F1_OVR];
  assign next_irq.error = err_summary && enable[can_irq_pkg::EN_ERR_MASTER];
  assign next_irq.wakeup = wakeup_flag && enable[can_irq_pkg::EN_WAKEUP];
  assign next_irq.sleep = sleep_flag && enable[can_irq_pkg::EN_SLEEP];

  // registered levels, one cycle behind their cause
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= '0;
    end else begin
      irq <= next_irq;
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  wire [31:0] rd_status = ({31'h0, err_summary} << can_irq_pkg::ST_ERR_SUMMARY) |
                          ({31'h0, wakeup_flag} << can_irq_pkg::ST_WAKEUP) |
                          ({31'h0, sleep_flag} << can_irq_pkg::ST_SLEEP);
  // release bit reads back as zero
  wire [31:0] rd_fifo0 = ({30'h0, fifo0.count} << can_irq_pkg::FIFO_CNT_LSB) |
                         ({31'h0, fifo0.full} << can_irq_pkg::FIFO_FULL) |
                         ({31'h0, fifo0.overrun} << can_irq_pkg::FIFO_OVR);
  wire [31:0] rd_fifo1 = ({30'h0, fifo1.count} << can_irq_pkg::FIFO_CNT_LSB) |
                         ({31'h0, fifo1.full} << can_irq_pkg::FIFO_FULL) |
                         ({31'h0, fifo1.overrun} << can_irq_pkg::FIFO_OVR);
  // reserved enable bits masked to zero
  wire [31:0] rd_enable = enable & can_irq_pkg::ENABLE_MASK;
  // only the low byte of the transmit counter is visible
  wire [31:0] rd_error = ({31'h0, warn_now} << can_irq_pkg::ERR_WARN) |
                         ({31'h0, passive_now} << can_irq_pkg::ERR_PASSIVE) |
                         ({31'h0, bus_off_now} << can_irq_pkg::ERR_BUS_OFF) |
                         ({29'h0, engine.last_error_code} << can_irq_pkg::ERR_LEC_LSB) |
                         ({24'h0, engine.tx_err_count[7:0]} << can_irq_pkg::ERR_TXC_LSB) |
                         ({24'h0, engine.rx_err_count} << can_irq_pkg::ERR_RXC_LSB);

  // unmapped addresses read as zero
  wire [31:0] rd_sel = ({32{hit_status}} & rd_status) |
                       ({32{hit_fifo0}} & rd_fifo0) |
                       ({32{hit_fifo1}} & rd_fifo1) |
                       ({32{hit_enable}} & rd_enable) |
                       ({32{hit_error}} & rd_error);
  wire [1:0] resp_sel = hit_any ? can_irq_pkg::RESP_OKAY : can_irq_pkg::RESP_DECODE_ERR;

  // data captured when taken, standing through the answer cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readdata <= 32'h0;
      response <= can_irq_pkg::RESP_OKAY;
    end else if (take_req) begin
      readdata <= read ? rd_sel : 32'h0;
      response <= resp_sel;
    end
  end

endmodule // can_irq_enable_logic
`default_nettype wire

// ==== sim/can_irq_enable_logic_props.sv ====
// assertion checker of the can interrupt enable logic
`timescale 1ns/10ps
`default_nettype none
module can_irq_enable_logic_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // engine and requests
  input wire can_irq_pkg::engine_in_t engine,
  input wire logic fifo0_release,
  input wire logic fifo1_release,
  input wire can_irq_pkg::irq_req_t irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow enable, rebuilt from completed writes only
  logic [31:0] en;
  wire done = !waitrequest && (read || write);
  wire [31:0] lane = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [31:0] next_en = (en & ~lane) | (writedata & lane & can_irq_pkg::ENABLE_MASK);
  wire en_hit = done && address == can_irq_pkg::OFF_ENABLE;
  always_ff @(posedge clk) begin
    if (!resetn)
      en <= 32'h0;
    else if (en_hit && write)
      en <= next_en;
  end
  tx_req_a: assert property (irq.tx == $past(|engine.mailbox_request_done && en[0]))
    else $error("tx request wrong");
  pend0_a: assert property (engine.fifo0_msg_in && en[1] && !write |=> ##1 irq.fifo0_pending)
    else $error("fifo0 pending missing");
  err_mask_a: assert property (!en[15] |=> !irq.error)
    else $error("error request unmasked");
  wake_on_a: assert property (engine.wakeup_event && en[16] && !write |=> ##1 irq.wakeup)
    else $error("wakeup request missing");
  wake_off_a: assert property (!en[16] |=> !irq.wakeup)
    else $error("wakeup request unmasked");
  sleep_off_a: assert property (!en[17] |=> !irq.sleep)
    else $error("sleep request unmasked");
  en_read_a: assert property (en_hit && read |-> readdata == en)
    else $error("enable readback wrong");
  release_a: assert property (done && write && address == 8'h0c && writedata[5] && byteenable[0]
    |=> fifo0_release)
    else $error("release pulse missing");
  release1_a: assert property (done && write && address == 8'h10 && writedata[5] && byteenable[0]
    |=> fifo1_release)
    else $error("fifo1 release pulse missing");
  cover property (en_hit && read);
  cover property (irq.error);
  cover property (fifo0_release);
endmodule // can_irq_enable_logic_props
bind can_irq_enable_logic can_irq_enable_logic_props can_irq_enable_logic_props_i (.clk, .resetn, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .engine, .fifo0_release, .fifo1_release, .irq);
`default_nettype wire

// ==== sim/can_engine_model.sv ====
// behavioural protocol engine feeding flags and counters
`timescale 1ns/10ps
`default_nettype none
module can_engine_model (
  // clock
  input wire logic clk,
  // flags towards the block
  output can_irq_pkg::engine_in_t engine
);
  can_irq_pkg::engine_in_t st;
  assign engine = st;
  // levels rest at zero until a scenario moves them
  initial st = '0;
  // one-cycle event pulses
  task automatic pulse(input can_irq_pkg::engine_in_t ev);
    @(posedge clk);
    st <= st | ev;
    @(posedge clk);
    st <= st & ~ev;
  endtask
  // error counter and mailbox done levels
  task automatic level(input logic [8:0] tx, input logic [2:0] mb);
    @(posedge clk);
    st.tx_err_count <= tx;
    st.mailbox_request_done <= mb;
  endtask
endmodule // can_engine_model
`default_nettype wire

// ==== sim/can_irq_enable_logic_tb_top.sv ====
// self-checking testbench of the can interrupt enable logic
`timescale 1ns/10ps
`default_nettype none
module can_irq_enable_logic_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata, q, d, lane, en_m;
  logic [1:0] response, r;
  logic waitrequest, fifo0_release, fifo1_release;
  can_irq_pkg::engine_in_t engine;
  can_irq_pkg::irq_req_t irq;
  can_irq_pkg::engine_in_t m;
  logic [9:0] x;
  logic [3:0] be;
  logic [2:0] mb;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'h732a47c2;
  int c, f, o;
  // free-running clock
  always #50 clk = ~clk;
  can_irq_enable_logic can_irq_enable_logic_i (.clk, .resetn, .address, .read, .write, .writedata,
    .byteenable, .readdata, .response, .waitrequest, .engine, .fifo0_release, .fifo1_release, .irq);
  can_engine_model can_engine_model_i (.clk, .engine);
  // verdict and end of run
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // compare one result word
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] wb);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    byteenable <= wb;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    bus(0, can_irq_pkg::OFF_ENABLE, 0, 4'hf);
    cmp(q, can_irq_pkg::ENABLE_RESET);
    bus(0, 8'h20, 0, 4'hf);
    cmp(q, 32'h0);
    cmp(32'(r), 32'(can_irq_pkg::RESP_DECODE_ERR));
    can_engine_model_i.level(9'd95, 3'h0);
    bus(0, can_irq_pkg::OFF_ERROR, 0, 4'hf);
    cmp(q, 32'h005f_0000);
    can_engine_model_i.level(9'd96, 3'h0);
    bus(0, can_irq_pkg::OFF_ERROR, 0, 4'hf);
    cmp(q, 32'h0060_0001);
    can_engine_model_i.level(9'd0, 3'h0);
    en_m = 32'h0;
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      be = (i < 2) ? 4'hf : 4'($random(seed));
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      en_m = (en_m & ~lane) | (d & lane & can_irq_pkg::ENABLE_MASK);
      bus(1, can_irq_pkg::OFF_ENABLE, d, be);
      bus(0, can_irq_pkg::OFF_ENABLE, 0, 4'hf);
      cmp(q, en_m);
      cmp(32'(r), 32'(can_irq_pkg::RESP_OKAY));
      mb = 3'($random(seed));
      can_engine_model_i.level(9'h100, mb);
      m = '0;
      m.wakeup_event = 1'b1;
      m.sleep_event = 1'b1;
      m.last_error_set = 1'b1;
      {c, f, o} = 0;
      for (int k = 0; k < 4; k++) begin
        m.fifo0_msg_in = 1'b1;
        m.fifo1_msg_in = 1'b1;
        can_engine_model_i.pulse(m);
        m = '0;
        if (c == 3)
          o = 1;
        else
          c++;
        f = (c == 3);
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
      x = {|mb & en_m[0], en_m[1], en_m[2], en_m[3], en_m[4], en_m[5], en_m[6],
        |en_m[11:8] & en_m[15], en_m[16], en_m[17]};
      cmp(32'(irq), 32'(x));
      bus(0, can_irq_pkg::OFF_FIFO0, 0, 4'hf);
      cmp(q, 32'(c + 8 * f + 16 * o));
      can_engine_model_i.level(9'h0, 3'h0);
      bus(1, can_irq_pkg::OFF_STATUS, 32'h7, 4'hf);
      repeat (3) begin
        bus(1, can_irq_pkg::OFF_FIFO0, 32'h38, 4'hf);
        bus(1, can_irq_pkg::OFF_FIFO1, 32'h38, 4'hf);
      end
      bus(0, can_irq_pkg::OFF_FIFO1, 0, 4'hf);
      cmp(q, 32'h0);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp(32'(irq), 32'h0);
    end
    stop_test();
  end
endmodule // can_irq_enable_logic_tb_top
`default_nettype wire
